// ==== testbench/pin_load_model.sv ====
/*
 * Load on the compare output pin: a weak pull-up holds the line while released.
 * Assumes the timer's active-low output enable.
 */
`timescale 1ns/1ps

module pin_load_model (
    input  wire logic compare_pin_out,
    input  wire logic compare_pin_oe_n,
    output logic      pin_level
);
    // Line level only follows the timer while its direction bit drives the pin
    assign pin_level = compare_pin_oe_n ? 1'b1 : compare_pin_out;
endmodule

// ==== testbench/tb.sv ====
/*
 * Self-checking bench for the compare-output timer over APB and timer ticks.
 * Assumes the register map header, the pin load model and the port checker.
 */
`timescale 1ns/1ps
`include "timer_compare_map.svh"

module tb;
    logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic        timer_tick, overflow_ack, compare_ack, compare_pin_out, compare_pin_oe_n;
    logic        overflow_flag, compare_match_flag, pin_level;
    int          err_total, comparisons;
    logic [1:0]  cs [3] = '{2'h2, 2'h3, 2'h0};
    logic        ex [3] = '{1'b0, 1'b1, 1'b1};

    timer_compare_output_ctc uut (
        .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_tick(timer_tick), .overflow_ack(overflow_ack), .compare_ack(compare_ack),
        .compare_pin_out(compare_pin_out), .compare_pin_oe_n(compare_pin_oe_n),
        .overflow_flag(overflow_flag), .compare_match_flag(compare_match_flag));
    pin_load_model load (.compare_pin_out(compare_pin_out), .compare_pin_oe_n(compare_pin_oe_n),
        .pin_level(pin_level));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic chkb(input logic seen, input logic exp);
        check({31'h0, seen}, {31'h0, exp});
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (n >= 64) begin
            err_total++;
            give_verdict();
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        check(q, x);
    endtask

    task automatic tick(input int n);
        timer_tick <= 1'b1;
        repeat (n) @(posedge sys_clk);
        timer_tick <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic ack(input logic o, input logic c);
        overflow_ack <= o;
        compare_ack  <= c;
        @(posedge sys_clk);
        overflow_ack <= 1'b0;
        compare_ack  <= 1'b0;
        @(posedge sys_clk);
    endtask

    function automatic logic [31:0] cfg(input logic [1:0] m, input logic [1:0] c, input logic [2:0] s,
                                        input logic f);
        return {24'h00_0000, f, s, c, m};
    endfunction

    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        give_verdict();
    end

    initial begin
        {rst_n, psel, penable, pwrite, timer_tick, overflow_ack, compare_ack} = 7'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        err_total = 0;
        comparisons = 0;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        chkb(compare_pin_oe_n, 1'b1);
        for (int i = 0; i < 5; i++) begin
            rd(12'(4 * i), 32'h0);
        end
        rd(12'h020, 32'h0);
        chkb(e, 1'b1);
        // ------------------------------------------------------------------
        // Force strobe, pin source and direction
        // ------------------------------------------------------------------
        wr(`TC_OFF_CTRL, cfg(2'h0, 2'h3, 3'h0, 1'b0));
        chkb(compare_pin_out, 1'b0);
        wr(`TC_OFF_CTRL, cfg(2'h0, 2'h3, 3'h0, 1'b1));
        chkb(compare_pin_out, 1'b1);
        wr(`TC_OFF_PORT, 32'h2);
        chkb(pin_level, 1'b1);
        wr(`TC_OFF_CTRL, cfg(2'h3, 2'h2, 3'h0, 1'b0));
        chkb(pin_level, 1'b1);
        wr(`TC_OFF_CTRL, cfg(2'h2, 2'h0, 3'h0, 1'b0));
        chkb(pin_level, 1'b0);
        wr(`TC_OFF_CTRL, cfg(2'h0, 2'h2, 3'h0, 1'b1));
        wr(`TC_OFF_CTRL, cfg(2'h0, 2'h2, 3'h0, 1'b1));
        chkb(pin_level, 1'b0);
        // ------------------------------------------------------------------
        // Normal mode wrap and overflow flag
        // ------------------------------------------------------------------
        wr(`TC_OFF_COUNT, 32'hfe);
        wr(`TC_OFF_COMPARE, 32'h80);
        wr(`TC_OFF_CTRL, cfg(2'h0, 2'h2, 3'h1, 1'b0));
        tick(1);
        rd(`TC_OFF_COUNT, 32'hff);
        chkb(overflow_flag, 1'b0);
        tick(1);
        chkb(overflow_flag, 1'b1);
        rd(`TC_OFF_COUNT, 32'h0);
        tick(1);
        chkb(overflow_flag, 1'b1);
        ack(1'b1, 1'b0);
        chkb(overflow_flag, 1'b0);
        // ------------------------------------------------------------------
        // Clear-on-match toggling and compare flag
        // ------------------------------------------------------------------
        wr(`TC_OFF_CTRL, cfg(2'h2, 2'h1, 3'h0, 1'b0));
        wr(`TC_OFF_COMPARE, 32'h2);
        wr(`TC_OFF_COUNT, 32'h0);
        wr(`TC_OFF_CTRL, cfg(2'h2, 2'h1, 3'h1, 1'b0));
        wr(`TC_OFF_STATUS, 32'h3);
        for (int k = 1; k <= 3; k++) begin
            tick(2);
            chkb(compare_match_flag, 1'b0);
            tick(1);
            rd(`TC_OFF_COUNT, 32'h0);
            chkb(pin_level, k[0]);
            chkb(compare_match_flag, 1'b1);
            if (k == 2) begin
                ack(1'b0, 1'b1);
            end else begin
                wr(`TC_OFF_STATUS, 32'h2);
            end
            chkb(compare_match_flag, 1'b0);
        end
        for (int i = 0; i < 3; i++) begin
            wr(`TC_OFF_CTRL, cfg(2'h2, cs[i], 3'h1, 1'b0));
            tick(3);
            wr(`TC_OFF_CTRL, cfg(2'h2, 2'h1, 3'h1, 1'b0));
            chkb(pin_level, ex[i]);
        end
        // ------------------------------------------------------------------
        // Missed match, blocking write, fastest toggle, stop, write priority
        // ------------------------------------------------------------------
        wr(`TC_OFF_COMPARE, 32'h40);
        wr(`TC_OFF_COUNT, 32'h50);
        wr(`TC_OFF_STATUS, 32'h3);
        tick(175);
        rd(`TC_OFF_COUNT, 32'hff);
        chkb(compare_match_flag, 1'b0);
        tick(65);
        rd(`TC_OFF_COUNT, 32'h40);
        tick(1);
        rd(`TC_OFF_COUNT, 32'h0);
        chkb(compare_match_flag, 1'b1);
        chkb(pin_level, 1'b0);
        wr(`TC_OFF_STATUS, 32'h3);
        wr(`TC_OFF_COMPARE, 32'h4);
        wr(`TC_OFF_COUNT, 32'h4);
        tick(1);
        rd(`TC_OFF_COUNT, 32'h5);
        chkb(compare_match_flag, 1'b0);
        chkb(pin_level, 1'b0);
        wr(`TC_OFF_COMPARE, 32'h5);
        tick(1);
        wr(`TC_OFF_COMPARE, 32'h0);
        for (int i = 0; i < 4; i++) begin
            tick(1);
            chkb(pin_level, i[0]);
        end
        rd(`TC_OFF_COUNT, 32'h0);
        wr(`TC_OFF_CTRL, cfg(2'h2, 2'h1, 3'h0, 1'b0));
        wr(`TC_OFF_COUNT, 32'h33);
        tick(3);
        rd(`TC_OFF_COUNT, 32'h33);
        wr(`TC_OFF_CTRL, cfg(2'h0, 2'h0, 3'h1, 1'b0));
        timer_tick <= 1'b1;
        wr(`TC_OFF_COUNT, 32'h20);
        timer_tick <= 1'b0;
        rd(`TC_OFF_COUNT, 32'h21);
        wr(`TC_OFF_COUNT, 32'hfe);
        wr(`TC_OFF_CTRL, cfg(2'h3, 2'h2, 3'h1, 1'b0));
        tick(2);
        chkb(pin_level, 1'b1);
        tick(1);
        chkb(pin_level, 1'b0);
        wr(`TC_OFF_COMPARE, 32'hfd);
        wr(`TC_OFF_COUNT, 32'hfe);
        wr(`TC_OFF_CTRL, cfg(2'h1, 2'h2, 3'h1, 1'b0));
        tick(4);
        chkb(pin_level, 1'b1);
        give_verdict();
    end
endmodule

bind timer_compare_output_ctc timer_compare_checker u_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_tick(timer_tick), .overflow_ack(overflow_ack), .compare_ack(compare_ack),
    .compare_pin_out(compare_pin_out), .compare_pin_oe_n(compare_pin_oe_n),
    .overflow_flag(overflow_flag), .compare_match_flag(compare_match_flag));

// ==== testbench/timer_compare_output_ctc_assertions.sv ====
/*
 * Port checker for the compare-output timer: flags, pin source and pin direction.
 * Assumes it is bound to timer_compare_output_ctc and sees only its ports.
 */
`timescale 1ns/1ps
`include "timer_compare_map.svh"

module timer_compare_checker (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        timer_tick,
    input wire logic        overflow_ack,
    input wire logic        compare_ack,
    input wire logic        compare_pin_out,
    input wire logic        compare_pin_oe_n,
    input wire logic        overflow_flag,
    input wire logic        compare_match_flag
);
    // ------------------------------------------------------------------
    // Shadow of the written action field and port bit
    // ------------------------------------------------------------------
    logic [1:0] com_r;
    logic       port_val_r;
    logic       wr_ctrl;
    logic       wr_stat;
    logic       wr_port;

    assign wr_ctrl = psel && penable && pwrite && (paddr == `TC_OFF_CTRL);
    assign wr_stat = psel && penable && pwrite && (paddr == `TC_OFF_STATUS);
    assign wr_port = psel && penable && pwrite && (paddr == `TC_OFF_PORT);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            com_r <= 2'h0;
        end else if (wr_ctrl) begin
            com_r <= pwdata[3:2];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            port_val_r <= 1'b0;
        end else if (wr_port) begin
            port_val_r <= pwdata[0];
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    AST_RST_CLEAR: assert property ($rose(rst_n) |-> !compare_pin_out && compare_pin_oe_n
        && !overflow_flag && !compare_match_flag) else $error("state not cleared by reset");
    AST_PIN_PORT: assert property (com_r == 2'h0 |-> compare_pin_out == port_val_r)
        else $error("pin not from port bit with action zero");
    AST_PIN_HOLD: assert property (com_r != 2'h0 && !timer_tick && !wr_ctrl |=> $stable(compare_pin_out))
        else $error("latch moved without match or force");
    AST_DIR_SET: assert property (wr_port |=> compare_pin_oe_n != $past(pwdata[1]))
        else $error("pin enable does not follow direction bit");
    AST_DIR_HOLD: assert property (!wr_port |=> $stable(compare_pin_oe_n))
        else $error("pin enable changed without port write");
    AST_OVF_KEEP: assert property (overflow_flag && !overflow_ack && !(wr_stat && pwdata[0]) |=> overflow_flag)
        else $error("overflow flag lost without clear");
    AST_OVF_ACK: assert property (overflow_ack && !timer_tick |=> !overflow_flag)
        else $error("overflow flag not cleared by service");
    AST_OVF_TICK: assert property (!overflow_flag && !timer_tick |=> !overflow_flag)
        else $error("overflow flag set without tick");
    AST_CMP_KEEP: assert property (compare_match_flag && !compare_ack && !(wr_stat && pwdata[1])
        |=> compare_match_flag) else $error("compare flag lost without clear");
    AST_CMP_TICK: assert property (!compare_match_flag && !timer_tick |=> !compare_match_flag)
        else $error("compare flag set without tick");
    AST_CMP_CLEAR: assert property (wr_stat && pwdata[1] && !timer_tick |=> !compare_match_flag)
        else $error("compare flag not cleared by write");

    cover property ($rose(overflow_flag));
    cover property ($rose(compare_match_flag));
    cover property (com_r != 2'h0 && $changed(compare_pin_out));
endmodule

// ==== verilog/timer_compare_map.svh ====
/*
 * Holds the register offsets, field positions, reset values and fixed counts of the
 * compare-output timer.
 * Assumes it is included by its bare name wherever these constants are needed.
 */
// Behaviour
// - Compare-action field decides what the output latch takes at the next match.
// - Reset forces the compare output latch to zero.
// - Nonzero compare-action field routes the latch to the pin instead of port bit.
// - Pin direction bit still steers the pin; software sets it to output.
// - Pin override depends only on the compare-action field, not the mode.
// - Compare-action zero leaves the latch unchanged on a match, in every mode.
// - New compare-action value acts at the first following match, unbuffered.
// - Force strobe in non-PWM modes applies the action at once.
// - Counting depends only on the waveform mode field.
// - In PWM modes the action selects inverted or non-inverted waveform.
// - In non-PWM modes the action sets, clears or toggles the latch.
// - Normal mode always increments, never clears, wraps 0xFF to 0x00.
// - Normal mode sets overflow flag in the tick the counter becomes zero.
// - Counting only sets the overflow flag; service or software clears it.
// - Normal mode accepts a counter write at any moment.
// - Mode 2 clears the counter on a compare match; compare is the top.
// - Clear-on-match mode sets the compare flag every period.
// - Clear-on-match mode compare writes take effect immediately.
// - Compare below count in clear-on-match mode misses until wrap.
// - Action 1 in clear-on-match mode toggles the latch each match.
// - Toggle with compare 0x00 toggles every timer tick.
// - Compare flag set the tick after a match; cleared by one or service.
// - Counter write blocks every match in the following timer tick.
// - Clock source zero stops the counter; it stays readable and writable.
// - Counter write beats any hardware clear or count in that cycle.
`ifndef TIMER_COMPARE_MAP_SVH
`define TIMER_COMPARE_MAP_SVH

// ---------------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------------
`define TC_OFF_CTRL      12'h000
`define TC_OFF_COUNT     12'h004
`define TC_OFF_COMPARE   12'h008
`define TC_OFF_STATUS    12'h00c
`define TC_OFF_PORT      12'h010

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define TC_CTRL_WGM_LSB  0
`define TC_CTRL_COM_LSB  2
`define TC_CTRL_CSS_LSB  4
`define TC_CTRL_FORCE    7
`define TC_STAT_OVF      0
`define TC_STAT_CMP      1
`define TC_PORT_VAL      0
`define TC_PORT_DIR      1

// ---------------------------------------------------------------------------
// Mode and action codes, reset values, counter extremes
// ---------------------------------------------------------------------------
`define TC_WGM_NORMAL    2'h0
`define TC_WGM_PHASE     2'h1
`define TC_WGM_MATCH_CLR 2'h2
`define TC_WGM_FAST      2'h3
`define TC_COM_NONE      2'h0
`define TC_COM_TOGGLE    2'h1
`define TC_COM_CLEAR     2'h2
`define TC_COM_SET       2'h3
`define TC_CSS_STOP      3'h0
`define TC_RST_CTRL      7'h00
`define TC_RST_BYTE      8'h00
`define TC_MAX           8'hff
`define TC_BOTTOM        8'h00

`endif

// ==== verilog/timer_compare_output_ctc.sv ====
/*
 * Eight-bit timer with compare output latch, pin override, normal, clear-on-match and
 * PWM modes, reached over an APB slave with zero wait states.
 * Assumes timer_tick is a one-cycle prescaled enable synchronous to sys_clk and that
 * the interrupt controller pulses the acknowledge inputs when it services a flag.
 */
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "timer_compare_map.svh"

module timer_compare_output_ctc (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        timer_tick,
    input  wire logic        overflow_ack,
    input  wire logic        compare_ack,
    output logic             compare_pin_out,
    output logic             compare_pin_oe_n,
    output logic             overflow_flag,
    output logic             compare_match_flag
);

    // ---------------------------------------------------------------------------
    // State
    // ---------------------------------------------------------------------------
    timer_compare_pkg::ctrl_s ctrl_r;
    logic [7:0]               counter_value_r;
    logic [7:0]               compare_buf_r;
    logic [7:0]               compare_act_r;
    logic                     count_down_r;
    logic                     block_r;
    logic                     compare_output_latch_r;
    logic                     overflow_flag_r;
    logic                     compare_flag_r;
    logic                     port_val_r;
    logic                     compare_pin_direction_bit_r;
    logic [31:0]              prdata_r;

    // ---------------------------------------------------------------------------
    // Bus decode
    // ---------------------------------------------------------------------------
    logic access;
    logic wr;
    logic hit_ctrl;
    logic hit_count;
    logic hit_compare;
    logic hit_status;
    logic hit_port;
    logic mapped;

    assign access      = psel && penable;
    assign wr          = access && pwrite;
    assign hit_ctrl    = (paddr == `TC_OFF_CTRL);
    assign hit_count   = (paddr == `TC_OFF_COUNT);
    assign hit_compare = (paddr == `TC_OFF_COMPARE);
    assign hit_status  = (paddr == `TC_OFF_STATUS);
    assign hit_port    = (paddr == `TC_OFF_PORT);
    assign mapped      = hit_ctrl || hit_count || hit_compare || hit_status || hit_port;
    assign pready      = 1'b1;
    assign pslverr     = access && !mapped;

    // ---------------------------------------------------------------------------
    // Timer events
    // ---------------------------------------------------------------------------
    logic [1:0] wgm;
    logic [1:0] com;
    logic       pwm_mode;
    logic       tick;
    logic       count_wr;
    logic       match;
    logic       force_hit;
    logic       at_max;
    logic       ovf_evt;
    logic [7:0] count_nxt;
    logic       down_nxt;

    assign wgm       = ctrl_r.waveform_mode_field;
    assign com       = ctrl_r.compare_action_field;
    assign pwm_mode  = (wgm == `TC_WGM_FAST) || (wgm == `TC_WGM_PHASE);
    assign tick      = timer_tick && (ctrl_r.clock_source_select != `TC_CSS_STOP);
    assign count_wr  = wr && hit_count;
    assign at_max    = (counter_value_r == `TC_MAX);
    assign force_hit = wr && hit_ctrl && pwdata[`TC_CTRL_FORCE] && !pwm_mode;
    // Match found on the tick that leaves the compare count; blocked after a count write
    assign match     = tick && (counter_value_r == compare_act_r) && !block_r;

    // Counting depends only on the mode field
    always_comb begin
        count_nxt = counter_value_r + 8'h01;
        down_nxt  = 1'b0;
        ovf_evt   = 1'b0;
        case (wgm)
            `TC_WGM_NORMAL: begin
                ovf_evt = at_max;
            end
            `TC_WGM_MATCH_CLR: begin
                ovf_evt = at_max;
                if (match) begin
                    count_nxt = `TC_BOTTOM;
                end
            end
            `TC_WGM_FAST: begin
                ovf_evt = at_max;
            end
            `TC_WGM_PHASE: begin
                if (count_down_r) begin
                    if (counter_value_r == `TC_BOTTOM) begin
                        count_nxt = counter_value_r + 8'h01;
                    end else begin
                        count_nxt = counter_value_r - 8'h01;
                        down_nxt  = 1'b1;
                    end
                    ovf_evt = (counter_value_r == 8'h01);
                end else if (at_max) begin
                    count_nxt = counter_value_r - 8'h01;
                    down_nxt  = 1'b1;
                end
            end
            default: begin
                count_nxt = counter_value_r;
            end
        endcase
    end

    // ---------------------------------------------------------------------------
    // Counter, direction and match blocking
    // ---------------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            counter_value_r <= `TC_RST_BYTE;
            count_down_r    <= 1'b0;
        end else if (count_wr) begin
            counter_value_r <= pwdata[7:0];
        end else if (tick) begin
            counter_value_r <= count_nxt;
            count_down_r    <= down_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            block_r <= 1'b0;
        end else if (count_wr) begin
            block_r <= 1'b1;
        end else if (tick) begin
            block_r <= 1'b0;
        end
    end

    // ---------------------------------------------------------------------------
    // Compare value: direct in non-PWM modes, buffered to the top in PWM modes
    // ---------------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            compare_buf_r <= `TC_RST_BYTE;
            compare_act_r <= `TC_RST_BYTE;
        end else begin
            if (wr && hit_compare) begin
                compare_buf_r <= pwdata[7:0];
            end
            if (wr && hit_compare && !pwm_mode) begin
                compare_act_r <= pwdata[7:0];
            end else if (pwm_mode && tick && at_max) begin
                compare_act_r <= compare_buf_r;
            end
        end
    end

    // ---------------------------------------------------------------------------
    // Compare output latch
    // ---------------------------------------------------------------------------
    logic latch_nxt;

    always_comb begin
        latch_nxt = compare_output_latch_r;
        if (!pwm_mode) begin
            if (match || force_hit) begin
                case (com)
                    `TC_COM_NONE:   latch_nxt = compare_output_latch_r;
                    `TC_COM_TOGGLE: latch_nxt = !compare_output_latch_r;
                    `TC_COM_CLEAR:  latch_nxt = 1'b0;
                    `TC_COM_SET:    latch_nxt = 1'b1;
                    default:        latch_nxt = compare_output_latch_r;
                endcase
            end
        end else if (com[1]) begin
            // Action 2 is non-inverted, action 3 inverted; 0 and 1 do nothing
            if (wgm == `TC_WGM_FAST) begin
                if (match) begin
                    latch_nxt = com[0];
                end
                if (tick && at_max) begin
                    latch_nxt = !com[0];
                end
            end else if (match) begin
                latch_nxt = count_down_r ? !com[0] : com[0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            compare_output_latch_r <= 1'b0;
        end else begin
            compare_output_latch_r <= latch_nxt;
        end
    end

    // ---------------------------------------------------------------------------
    // Flags: a hardware set wins over a clear in the same cycle
    // ---------------------------------------------------------------------------
    logic ovf_clr;
    logic cmp_clr;

    assign ovf_clr = overflow_ack || (wr && hit_status && pwdata[`TC_STAT_OVF]);
    assign cmp_clr = compare_ack || (wr && hit_status && pwdata[`TC_STAT_CMP]);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            overflow_flag_r <= 1'b0;
        end else if (tick && ovf_evt && !count_wr) begin
            overflow_flag_r <= 1'b1;
        end else if (ovf_clr) begin
            overflow_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            compare_flag_r <= 1'b0;
        end else if (match) begin
            compare_flag_r <= 1'b1;
        end else if (cmp_clr) begin
            compare_flag_r <= 1'b0;
        end
    end

    // ---------------------------------------------------------------------------
    // Control and port registers
    // ---------------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl_r <= `TC_RST_CTRL;
        end else if (wr && hit_ctrl) begin
            ctrl_r.waveform_mode_field  <= pwdata[`TC_CTRL_WGM_LSB +: 2];
            ctrl_r.compare_action_field <= pwdata[`TC_CTRL_COM_LSB +: 2];
            ctrl_r.clock_source_select  <= pwdata[`TC_CTRL_CSS_LSB +: 3];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            port_val_r                  <= 1'b0;
            compare_pin_direction_bit_r <= 1'b0;
        end else if (wr && hit_port) begin
            port_val_r                  <= pwdata[`TC_PORT_VAL];
            compare_pin_direction_bit_r <= pwdata[`TC_PORT_DIR];
        end
    end

    // ---------------------------------------------------------------------------
    // Read data, registered at the setup phase
    // ---------------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            prdata_r <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_r <= 32'h0000_0000;
            case (paddr)
                `TC_OFF_CTRL:    prdata_r[6:0] <= ctrl_r;
                `TC_OFF_COUNT:   prdata_r[7:0] <= counter_value_r;
                `TC_OFF_COMPARE: prdata_r[7:0] <= compare_buf_r;
                `TC_OFF_STATUS:  prdata_r[1:0] <= {compare_flag_r, overflow_flag_r};
                `TC_OFF_PORT:    prdata_r[1:0] <= {compare_pin_direction_bit_r, port_val_r};
                default:         prdata_r <= 32'h0000_0000;
            endcase
        end
    end

    assign prdata = prdata_r;

    // ---------------------------------------------------------------------------
    // Pin
    // ---------------------------------------------------------------------------
    assign compare_pin_out    = (com != `TC_COM_NONE) ? compare_output_latch_r : port_val_r;
    assign compare_pin_oe_n   = !compare_pin_direction_bit_r;
    assign overflow_flag      = overflow_flag_r;
    assign compare_match_flag = compare_flag_r;

endmodule

// ==== verilog/timer_compare_pkg.sv ====
/*
 * Types shared by the compare-output timer: the control register layout.
 * Assumes the constants header gives the field codes.
 */
package timer_compare_pkg;

    typedef struct packed {
        logic [2:0] clock_source_select;
        logic [1:0] compare_action_field;
        logic [1:0] waveform_mode_field;
    } ctrl_s;

endpackage
